// ### rtl/drs_pkg.sv
package drs_pkg;

    // memory geometry
    localparam int unsigned MEM_BYTES    = 64;
    localparam int unsigned ADDR_W       = 6;
    localparam int unsigned REG_COUNT    = 8;
    localparam int unsigned STACK_BASE   = 8;
    localparam int unsigned STACK_BYTES  = 16;
    localparam int unsigned SP_W         = 3;
    localparam int unsigned PC_W         = 16;

    // reset values
    localparam logic [2:0] SP_RESET      = 3'h0;
    localparam logic [7:0] DATA_RESET    = 8'h00;

    // access kinds requested by the sequencer
    typedef enum logic [2:0] {
        DRS_OP_NONE  = 3'b000,
        DRS_OP_RDREG = 3'b001,
        DRS_OP_WRREG = 3'b010,
        DRS_OP_RDIND = 3'b011,
        DRS_OP_WRIND = 3'b100,
        DRS_OP_PUSH  = 3'b101,
        DRS_OP_POP   = 3'b110
    } drs_op_e;

endpackage

// ### rtl/drs_mem.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// byte memory, two write ports (one byte each), two async read ports
module drs_mem #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned AW    = 6
) (
    // clock
    input  wire logic          clock,
    // write port a
    input  wire logic          we_a,
    input  wire logic [AW-1:0] wa_a,
    input  wire logic [7:0]    wd_a,
    // write port b
    input  wire logic          we_b,
    input  wire logic [AW-1:0] wa_b,
    input  wire logic [7:0]    wd_b,
    // read ports
    input  wire logic [AW-1:0] ra_a,
    output logic      [7:0]    rd_a,
    input  wire logic [AW-1:0] ra_b,
    output logic      [7:0]    rd_b
);

    // refuse a depth the address cannot reach
    if (DEPTH > (1 << AW)) begin : g_chk_depth
        $error("drs_mem: depth exceeds address range");
    end

    logic [7:0] mem [DEPTH];

    // storage; no reset so it maps to ram
    always_ff @(posedge clock) begin
        if (we_a) begin
            mem[wa_a] <= wd_a;
        end
        if (we_b) begin
            mem[wa_b] <= wd_b;
        end
    end

    // combinational read
    assign rd_a = mem[ra_a];
    assign rd_b = mem[ra_b];

endmodule // drs_mem

// ### rtl/drs_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// RL1: one 64-byte memory for data and stack
// RL2: bytes 0-7 are directly addressed working registers
// RL3: registers 0 and 1 point anywhere indirectly
// RL4: bytes 8-23 hold eight two-byte return addresses
// RL5: 3-bit pointer selects next free slot
// RL6: push increments pointer, return decrements it
// RL7: calls and interrupt entry both push
// RL8: unused stack bytes remain ordinary data memory
// RL9: interrupt entry saves only program counter
// RL10: pointer resets to zero, wraps silently
module drs_top (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // request from sequencer
    input  wire logic [2:0]                      op,
    input  wire logic [2:0]                      reg_sel,
    input  wire logic                            ptr_sel,
    input  wire logic [7:0]                      wdata,
    input  wire logic [drs_pkg::PC_W-1:0]        push_pc,
    input  wire logic                            push_irq,
    // answer to sequencer
    output logic                                 rvalid,
    output logic      [7:0]                      rdata,
    output logic      [drs_pkg::PC_W-1:0]        pop_pc,
    output logic                                 pop_irq,
    output logic      [drs_pkg::SP_W-1:0]        sp
);

    typedef struct packed {
        logic                      rvalid;
        logic [7:0]                rdata;
        logic [drs_pkg::PC_W-1:0]  pop_pc;
        logic                      pop_irq;
        logic [drs_pkg::SP_W-1:0]  sp;
        logic [7:0]                irq_mark;  // one bit per slot: pushed by interrupt
    } drs_state_s;

    // value of every state bit after reset
    localparam drs_state_s ST_RESET = '{
        rvalid:   1'b0,
        rdata:    drs_pkg::DATA_RESET,
        pop_pc:   '0,
        pop_irq:  1'b0,
        sp:       drs_pkg::SP_RESET,     // RL10
        irq_mark: 8'h00
    };

    // write data parked on port b while it is idle
    localparam logic [7:0] DATA_ZERO = drs_pkg::DATA_RESET;

    // first stack byte, right above the working registers
    localparam logic [drs_pkg::ADDR_W-1:0] STACK_BASE_A = 6'(drs_pkg::STACK_BASE);

    drs_state_s st_q;
    drs_state_s st_d;

    logic                        we_a;
    logic                        we_b;
    logic [drs_pkg::ADDR_W-1:0]  wa_a;
    logic [drs_pkg::ADDR_W-1:0]  wa_b;
    logic [7:0]                  wd_a;
    logic [7:0]                  wd_b;
    logic [drs_pkg::ADDR_W-1:0]  ra_a;
    logic [drs_pkg::ADDR_W-1:0]  ra_b;
    logic [7:0]                  rd_a;
    logic [7:0]                  rd_b;
    logic [drs_pkg::ADDR_W-1:0]  reg_addr;
    logic [drs_pkg::ADDR_W-1:0]  ptr_addr;
    logic [drs_pkg::ADDR_W-1:0]  push_lo;
    logic [drs_pkg::ADDR_W-1:0]  pop_lo;
    logic [drs_pkg::SP_W-1:0]    sp_dec;
    logic [7:0]                  ptr_byte;
    drs_pkg::drs_op_e            op_e;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks on the geometry the steering below assumes

    // one address must reach every byte
    if (drs_pkg::MEM_BYTES != (1 << drs_pkg::ADDR_W)) begin : g_chk_depth // RL1
        $error("drs_top: memory size and address width disagree");
    end

    // reg_sel is three bits wide
    if (drs_pkg::REG_COUNT != 8) begin : g_chk_regs // RL2
        $error("drs_top: working register count must be 8");
    end

    // stack starts straight after the registers
    if (drs_pkg::STACK_BASE != drs_pkg::REG_COUNT) begin : g_chk_base // RL4
        $error("drs_top: stack must sit right above the registers");
    end

    // two bytes for each slot the pointer can name
    if (drs_pkg::STACK_BYTES != (2 << drs_pkg::SP_W)) begin : g_chk_slots // RL4
        $error("drs_top: stack size and pointer width disagree");
    end

    // stack lies wholly inside the memory
    if (drs_pkg::STACK_BASE + drs_pkg::STACK_BYTES > drs_pkg::MEM_BYTES) begin : g_chk_fit // RL1
        $error("drs_top: stack runs past the end of memory");
    end

    // pointer width, slot marks and reset value agree
    if (drs_pkg::SP_W != 3 || $bits(drs_pkg::SP_RESET) != drs_pkg::SP_W) begin : g_chk_sp // RL5
        $error("drs_top: stack pointer must be 3 bits");
    end

    // each return address fills exactly two bytes
    if (drs_pkg::PC_W != 16) begin : g_chk_pc // RL4
        $error("drs_top: return address must be 16 bits");
    end

    ////////////////////////////////////////////////////////////////////////////
    // single shared store for registers, stack and data
    drs_mem #(
        .DEPTH (drs_pkg::MEM_BYTES),
        .AW    (drs_pkg::ADDR_W)
    ) u_mem ( // RL1
        .clock (clock),
        .we_a  (we_a),
        .wa_a  (wa_a),
        .wd_a  (wd_a),
        .we_b  (we_b),
        .wa_b  (wa_b),
        .wd_b  (wd_b),
        .ra_a  (ra_a),
        .rd_a  (rd_a),
        .ra_b  (ra_b),
        .rd_b  (rd_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address arithmetic
    assign op_e     = drs_pkg::drs_op_e'(op);
    assign reg_addr = {3'h0, reg_sel};                                   // RL2
    assign ptr_byte = rd_b;                                              // RL3
    assign ptr_addr = ptr_byte[drs_pkg::ADDR_W-1:0];                     // RL3
    assign sp_dec   = st_q.sp - 3'h1;                                    // RL10
    assign push_lo  = STACK_BASE_A + {2'h0, st_q.sp, 1'b0};              // RL4 RL5
    assign pop_lo   = STACK_BASE_A + {2'h0, sp_dec, 1'b0};               // RL4

    ////////////////////////////////////////////////////////////////////////////
    // memory port steering
    always_comb begin
        we_a = 1'b0;
        we_b = 1'b0;
        wa_a = reg_addr;
        wa_b = reg_addr;
        wd_a = wdata;
        wd_b = DATA_ZERO;
        ra_a = reg_addr;
        ra_b = {5'h00, ptr_sel};                                         // RL3
        unique case (op_e)
            drs_pkg::DRS_OP_WRREG: begin
                we_a = 1'b1;                                             // RL2
            end
            drs_pkg::DRS_OP_RDIND: begin
                ra_a = ptr_addr;                                         // RL8
            end
            drs_pkg::DRS_OP_WRIND: begin
                we_a = 1'b1;
                wa_a = ptr_addr;                                         // RL3
            end
            drs_pkg::DRS_OP_PUSH: begin
                // two bytes in one cycle; only the pc is saved
                we_a = 1'b1;                                             // RL9
                we_b = 1'b1;
                wa_a = push_lo;
                wd_a = push_pc[7:0];
                wa_b = push_lo + 6'h01;
                wd_b = push_pc[15:8];                                    // RL7
            end
            drs_pkg::DRS_OP_POP: begin
                ra_a = pop_lo;
                ra_b = pop_lo + 6'h01;
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;
        unique case (op_e)
            drs_pkg::DRS_OP_RDREG,
            drs_pkg::DRS_OP_RDIND: begin
                st_d.rvalid = 1'b1;
                st_d.rdata  = rd_a;
            end
            drs_pkg::DRS_OP_PUSH: begin
                st_d.irq_mark[st_q.sp] = push_irq;                       // RL7
                st_d.sp                = st_q.sp + 3'h1;                 // RL6 RL10
            end
            drs_pkg::DRS_OP_POP: begin
                st_d.rvalid  = 1'b1;
                st_d.pop_pc  = {rd_b, rd_a};
                st_d.pop_irq = st_q.irq_mark[sp_dec];
                st_d.sp      = sp_dec;                                   // RL6 RL10
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= ST_RESET;                                            // RL10
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign rvalid  = st_q.rvalid;
    assign rdata   = st_q.rdata;
    assign pop_pc  = st_q.pop_pc;
    assign pop_irq = st_q.pop_irq;
    assign sp      = st_q.sp;

endmodule // drs_top

// ### tb/drs_top_asserts.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// port-level checks of the data ram and return stack
module drs_top_asserts (
    // clock and reset
    input wire logic                     clock,
    input wire logic                     rst,
    // request
    input wire logic [2:0]               op,
    input wire logic [2:0]               reg_sel,
    input wire logic [7:0]               wdata,
    input wire logic [drs_pkg::PC_W-1:0] push_pc,
    input wire logic                     push_irq,
    // answer
    input wire logic                     rvalid,
    input wire logic [7:0]               rdata,
    input wire logic [drs_pkg::PC_W-1:0] pop_pc,
    input wire logic                     pop_irq,
    input wire logic [2:0]               sp
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // request kinds that expect an answer
    logic rd_op;
    assign rd_op = (op == 3'h1) || (op == 3'h3) || (op == 3'h6);

    sequence s_push; op == 3'h5; endsequence
    sequence s_pop; op == 3'h6; endsequence
    sequence s_wr; op == 3'h2; endsequence
    sequence s_rd_same; op == 3'h1 && reg_sel == $past(reg_sel); endsequence

    AST_READ_ANS: assert property (rd_op |=> rvalid) else $error("read not answered");
    AST_NO_ANS: assert property (!rd_op |=> !rvalid) else $error("stray rvalid");
    AST_SP_UP: assert property (s_push |=> sp == $past(sp) + 3'h1)
        else $error("sp not raised by push");
    AST_SP_DOWN: assert property (s_pop |=> sp == $past(sp) - 3'h1)
        else $error("sp not lowered by pop");
    AST_SP_KEEP: assert property (op != 3'h5 && op != 3'h6 |=> $stable(sp))
        else $error("sp moved without stack op");
    AST_CALL_RET: assert property (s_push ##1 s_pop |=> pop_pc == $past(push_pc, 2))
        else $error("popped address differs");
    AST_IRQ_MARK: assert property (s_push ##1 s_pop |=> pop_irq == $past(push_irq, 2))
        else $error("popped entry kind differs");
    AST_REG_RW: assert property (s_wr ##1 s_rd_same |=> rdata == $past(wdata, 2))
        else $error("register read after write wrong");
    AST_RST_SP: assert property ($fell(rst) |-> sp == 3'h0 && !rvalid)
        else $error("sp not zero after reset");
endmodule // drs_top_asserts

bind drs_top drs_top_asserts u_chk (.clock(clock), .rst(rst), .op(op), .reg_sel(reg_sel),
    .wdata(wdata), .push_pc(push_pc), .push_irq(push_irq), .rvalid(rvalid), .rdata(rdata),
    .pop_pc(pop_pc), .pop_irq(pop_irq), .sp(sp));

// ### tb/drs_seq_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// sequencer stand-in: one request per clock, changed just after the edge
module drs_seq_model (
    // clock
    input wire logic                clock,
    // request to the ram
    output logic [2:0]               op,
    output logic [2:0]               reg_sel,
    output logic                     ptr_sel,
    output logic [7:0]               wdata,
    output logic [drs_pkg::PC_W-1:0] push_pc,
    output logic                     push_irq
);
    // idle request at time zero
    initial begin
        op = 3'h0;
        {reg_sel, ptr_sel, wdata, push_pc, push_irq} = '0;
    end

    // drive one request, selector doubles as pointer choice
    task automatic go(input logic [2:0] o, input logic [2:0] s, input logic [7:0] d,
                      input logic [15:0] pc, input logic irq);
        @(posedge clock);
        #1;
        op = o;
        reg_sel = s;
        ptr_sel = s[0];
        wdata = d;
        push_pc = pc;
        push_irq = irq;
    endtask
endmodule // drs_seq_model

// ### tb/tb_drs_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the data ram and return stack
module tb_drs_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  op, reg_sel, sp;
    logic        ptr_sel, push_irq, rvalid, pop_irq;
    logic [7:0]  wdata, rdata;
    logic [15:0] push_pc, pop_pc;
    int          n_fail = 0;
    int          checks_done = 0;

    // 200 MHz clock
    always #2.5 clock = ~clock;

    drs_seq_model seq (.clock(clock), .op(op), .reg_sel(reg_sel), .ptr_sel(ptr_sel),
        .wdata(wdata), .push_pc(push_pc), .push_irq(push_irq));
    drs_top uut (.clock(clock), .rst(rst), .op(op), .reg_sel(reg_sel), .ptr_sel(ptr_sel),
        .wdata(wdata), .push_pc(push_pc), .push_irq(push_irq), .rvalid(rvalid),
        .rdata(rdata), .pop_pc(pop_pc), .pop_irq(pop_irq), .sp(sp));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // read or pop, then compare the answer one cycle later
    task automatic rd(input logic [2:0] o, input logic [2:0] s, input logic [15:0] e);
        seq.go(o, s, 8'h00, 16'h0000, 1'b0);
        seq.go(3'h0, s, 8'h00, 16'h0000, 1'b0);
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        chk("data", e, (o == 3'h6) ? pop_pc : {8'h00, rdata});
    endtask

    task automatic t_regs;
        for (int i = 0; i < 8; i++) seq.go(3'h2, i[2:0], 8'hA0 + i[7:0], 16'h0000, 1'b0);
        for (int i = 7; i >= 0; i--) rd(3'h1, i[2:0], 16'h00A0 + i[15:0]);
    endtask

    task automatic t_ind;
        seq.go(3'h2, 3'h0, 8'h3F, 16'h0000, 1'b0);
        seq.go(3'h4, 3'h0, 8'h5A, 16'h0000, 1'b0);
        rd(3'h3, 3'h0, 16'h005A);
        seq.go(3'h2, 3'h1, 8'h0A, 16'h0000, 1'b0);
        seq.go(3'h4, 3'h1, 8'hC3, 16'h0000, 1'b0);
        rd(3'h3, 3'h1, 16'h00C3);
        seq.go(3'h2, 3'h1, 8'h02, 16'h0000, 1'b0);
        rd(3'h3, 3'h1, 16'h00A2);
    endtask

    task automatic t_stack;
        seq.go(3'h2, 3'h0, 8'h08, 16'h0000, 1'b0);
        for (int i = 0; i < 8; i++)
            seq.go(3'h5, 3'h0, 8'h00, 16'h12C4 + 16'h0111 * i[15:0], i[0]);
        seq.go(3'h0, 3'h0, 8'h00, 16'h0000, 1'b0);
        chk("sp", 16'h0000, {13'h0000, sp});
        rd(3'h3, 3'h0, 16'h00C4);
        for (int i = 7; i >= 0; i--) begin
            rd(3'h6, 3'h0, 16'h12C4 + 16'h0111 * i[15:0]);
            chk("irq", {15'h0000, i[0]}, {15'h0000, pop_irq});
            chk("sp", i[15:0], {13'h0000, sp});
        end
        seq.go(3'h5, 3'h0, 8'h00, 16'hBEEF, 1'b1);
        rd(3'h6, 3'h0, 16'hBEEF);
        chk("irq", 16'h0001, {15'h0000, pop_irq});
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        t_regs;
        t_ind;
        t_stack;
        report_and_stop;
    end

    // watchdog well beyond the roughly 80 cycles the tests need
    initial begin
        #20000;
        n_fail++;
        report_and_stop;
    end
endmodule // tb_drs_top
